// *** design/dcc_consts.svh ***
// register offsets, bit positions and reset values of the comparator control
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH
`define DCC_ADDR_W 8
`define DCC_OFS_PORT_DATA 8'h05
`define DCC_OFS_GIC 8'h0b
`define DCC_OFS_FLAGS 8'h0c
`define DCC_OFS_CFG 8'h1f
`define DCC_OFS_DIR 8'h85
`define DCC_OFS_IEN 8'h8c
`define DCC_BIT_GLOBAL_EN 7
`define DCC_BIT_PERIPH_EN 6
`define DCC_BIT_CHANGE 6
`define DCC_BIT_FIRST_PIN 3
`define DCC_BIT_SECOND_PIN 4
`define DCC_RST_GIC 8'h00
`define DCC_RST_FLAGS 8'h00
`define DCC_RST_CFG 6'h00
`define DCC_RST_DIR 8'hff
`define DCC_RST_IEN 8'h00
`define DCC_RST_LATCH 8'h00
`define DCC_FLAGS_MASK 8'hf7
`define DCC_IEN_MASK 8'hf7
`define DCC_ANA_ALL 8'h0f
`define DCC_ANA_LOW3 8'h07
`define DCC_ANA_NONE 8'h00
`endif

// *** design/dcc_pkg.sv ***
// types of the dual comparator control block
package dcc_pkg;
   typedef enum logic [2:0] {
      DCC_MODE_RESET = 3'b000,
      DCC_MODE_MUX3 = 3'b001,
      DCC_MODE_VREF = 3'b010,
      DCC_MODE_COMMON = 3'b011,
      DCC_MODE_TWO = 3'b100,
      DCC_MODE_ONE = 3'b101,
      DCC_MODE_OUTPUTS = 3'b110,
      DCC_MODE_OFF = 3'b111
   } dcc_mode_t;

   typedef struct packed {
      logic second_result_invert;
      logic first_result_invert;
      logic input_switch_select;
      dcc_mode_t comparator_mode_field;
   } dcc_cfg_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } dcc_pins_t;

   typedef struct packed {
      logic vref_to_positive;
      logic alt_negative;
      logic power_en;
   } dcc_analog_t;

   typedef struct packed {
      logic [7:0] global_interrupt_control;
      logic [7:0] peripheral_irq_flags;
      dcc_cfg_t comparator_config;
      logic [7:0] port_pin_direction;
      logic [7:0] peripheral_irq_enables;
      logic [7:0] port_latch;
      logic [7:0] pin_s1;
      logic [7:0] pin_s2;
      logic [1:0] cmp_s1;
      logic [1:0] cmp_s2;
      logic [1:0] last_read;
      logic [7:0] rdata;
      logic irq;
      logic wake;
      dcc_pins_t pins;
      dcc_analog_t analog;
   } dcc_state_t;
endpackage : dcc_pkg

// *** design/dcc_top.sv ***
// digital control and status logic of the dual comparator
//
// Summary of operation
// - result high when positive above negative
// - mode 010 routes reference to positives
// - top config bits show results, read-only
// - modes 110/001 route results to pins
// - direction bits still enable those pins
// - analog pins read zero on port
// - any result change sets change flag
// - flag bit 6, write sets or clears
// - request needs flag and all enables
// - read-coincident change still sets flag
// - mismatch keeps setting the flag
// - config access captures results, ends mismatch
// - comparators run and wake during sleep
// - mode 111 powers both comparators off
// - waking keeps config register unchanged
// - reset clears config, comparators powered down
// - invert bit flips result everywhere
// - switch bit picks negative input pins
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "dcc_consts.svh"

module dcc_top
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // register port
   input wire logic [`DCC_ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // analog comparator cores
   input wire logic [1:0] i_cmp_raw,
   output logic o_vref_to_positive,
   output logic o_alt_negative,
   output logic o_cmp_power_en,
   // port pins
   input wire logic [7:0] i_pin_in,
   output logic [7:0] o_pin_out,
   output logic [7:0] o_pin_oe,
   // system
   input wire logic i_sleep,
   output logic o_irq,
   output logic o_wake
);

   dcc_state_t s_r;
   dcc_state_t s_nxt;

   // pins that the mode leaves analog
   function automatic logic [7:0] analog_mask(input dcc_mode_t m);
      logic [7:0] r;
      r = `DCC_ANA_NONE;
      unique case (m)
         DCC_MODE_RESET: r = `DCC_ANA_ALL;
         DCC_MODE_MUX3: r = `DCC_ANA_LOW3;
         DCC_MODE_VREF: r = `DCC_ANA_ALL;
         DCC_MODE_COMMON: r = `DCC_ANA_LOW3;
         DCC_MODE_TWO: r = `DCC_ANA_ALL;
         DCC_MODE_ONE: r = `DCC_ANA_LOW3;
         DCC_MODE_OUTPUTS: r = `DCC_ANA_LOW3;
         DCC_MODE_OFF: r = `DCC_ANA_NONE;
      endcase
      return r;
   endfunction : analog_mask

   // modes that put the results on the pins
   function automatic logic mode_routes_pins(input dcc_mode_t m);
      logic r;
      r = 1'b0;
      unique case (m)
         DCC_MODE_RESET: r = 1'b0;
         DCC_MODE_MUX3: r = 1'b1;
         DCC_MODE_VREF: r = 1'b0;
         DCC_MODE_COMMON: r = 1'b0;
         DCC_MODE_TWO: r = 1'b0;
         DCC_MODE_ONE: r = 1'b0;
         DCC_MODE_OUTPUTS: r = 1'b1;
         DCC_MODE_OFF: r = 1'b0;
      endcase
      return r;
   endfunction : mode_routes_pins

   // switch bit matters in two modes only
   function automatic logic mode_uses_switch(input dcc_mode_t m);
      logic r;
      r = 1'b0;
      unique case (m)
         DCC_MODE_RESET: r = 1'b0;
         DCC_MODE_MUX3: r = 1'b1;
         DCC_MODE_VREF: r = 1'b1;
         DCC_MODE_COMMON: r = 1'b0;
         DCC_MODE_TWO: r = 1'b0;
         DCC_MODE_ONE: r = 1'b0;
         DCC_MODE_OUTPUTS: r = 1'b0;
         DCC_MODE_OFF: r = 1'b0;
      endcase
      return r;
   endfunction : mode_uses_switch

   function automatic logic mode_powered(input dcc_mode_t m);
      logic r;
      r = 1'b0;
      unique case (m)
         DCC_MODE_RESET: r = 1'b0;
         DCC_MODE_MUX3: r = 1'b1;
         DCC_MODE_VREF: r = 1'b1;
         DCC_MODE_COMMON: r = 1'b1;
         DCC_MODE_TWO: r = 1'b1;
         DCC_MODE_ONE: r = 1'b1;
         DCC_MODE_OUTPUTS: r = 1'b1;
         DCC_MODE_OFF: r = 1'b0;
      endcase
      return r;
   endfunction : mode_powered

   // reference only in its own mode
   function automatic logic mode_uses_vref(input dcc_mode_t m);
      logic r;
      r = 1'b0;
      unique case (m)
         DCC_MODE_RESET: r = 1'b0;
         DCC_MODE_MUX3: r = 1'b0;
         DCC_MODE_VREF: r = 1'b1;
         DCC_MODE_COMMON: r = 1'b0;
         DCC_MODE_TWO: r = 1'b0;
         DCC_MODE_ONE: r = 1'b0;
         DCC_MODE_OUTPUTS: r = 1'b0;
         DCC_MODE_OFF: r = 1'b0;
      endcase
      return r;
   endfunction : mode_uses_vref

   // flag and both change enables set
   function automatic logic change_armed(
      input logic [7:0] flags,
      input logic [7:0] ien,
      input logic [7:0] gic
   );
      logic r;
      r = flags[`DCC_BIT_CHANGE] & ien[`DCC_BIT_CHANGE];
      r = r & gic[`DCC_BIT_PERIPH_EN];
      return r;
   endfunction : change_armed

   // results replace the latch on two pins
   function automatic logic [7:0] pin_drive(
      input logic [7:0] latch,
      input logic [1:0] res,
      input logic route
   );
      logic [7:0] r;
      r = latch;
      if (route) begin
         r[`DCC_BIT_FIRST_PIN] = res[0];
         r[`DCC_BIT_SECOND_PIN] = res[1];
      end
      return r;
   endfunction : pin_drive

   // analog pins read back as zero
   function automatic logic [7:0] port_read(
      input logic [7:0] pins,
      input dcc_mode_t m
   );
      logic [7:0] r;
      r = pins & ~analog_mask(m);
      return r;
   endfunction : port_read

   function automatic logic [7:0] cfg_readback(
      input logic [1:0] res,
      input dcc_cfg_t cfg
   );
      logic [7:0] r;
      r = {res, cfg};
      return r;
   endfunction : cfg_readback

   // only the low six bits are writable
   function automatic dcc_cfg_t cfg_from_write(input logic [7:0] d);
      dcc_cfg_t r;
      r = {d[5:3], dcc_mode_t'(d[2:0])};
      return r;
   endfunction : cfg_from_write

   // unimplemented bit position stays zero
   function automatic logic [7:0] keep_defined(
      input logic [7:0] d,
      input logic [7:0] mask
   );
      logic [7:0] r;
      r = d & mask;
      return r;
   endfunction : keep_defined

   function automatic logic results_differ(
      input logic [1:0] now_res,
      input logic [1:0] captured
   );
      logic r;
      r = (now_res != captured);
      return r;
   endfunction : results_differ

   function automatic logic [1:0] apply_invert(
      input logic [1:0] res,
      input logic [1:0] inv_bits
   );
      logic [1:0] r;
      r = res ^ inv_bits;
      return r;
   endfunction : apply_invert

   logic [1:0] inv;
   logic [1:0] cur;
   logic [1:0] raw_inv;
   logic cfg_access;
   logic mismatch;
   logic route_pins;
   dcc_mode_t mode;

   assign mode = s_r.comparator_config.comparator_mode_field;
   assign inv = {s_r.comparator_config.second_result_invert,
                 s_r.comparator_config.first_result_invert};
   assign cur = apply_invert(s_r.cmp_s2, inv);
   assign raw_inv = apply_invert(i_cmp_raw, inv);
   assign cfg_access = (i_wr | i_rd) && (i_addr == `DCC_OFS_CFG);
   assign mismatch = results_differ(cur, s_r.last_read);
   assign route_pins = mode_routes_pins(mode);

   always_comb begin
      s_nxt = s_r;
      // raw bit high for positive above negative
      s_nxt.cmp_s1 = i_cmp_raw;
      s_nxt.cmp_s2 = s_r.cmp_s1;
      s_nxt.pin_s1 = i_pin_in;
      s_nxt.pin_s2 = s_r.pin_s1;

      // register writes
      if (i_wr) begin
         unique case (i_addr)
            `DCC_OFS_GIC: s_nxt.global_interrupt_control = i_wdata;
            `DCC_OFS_FLAGS: begin
               s_nxt.peripheral_irq_flags =
                  keep_defined(i_wdata, `DCC_FLAGS_MASK);
            end
            `DCC_OFS_CFG: begin
               s_nxt.comparator_config = cfg_from_write(i_wdata);
            end
            `DCC_OFS_DIR: s_nxt.port_pin_direction = i_wdata;
            `DCC_OFS_IEN: begin
               s_nxt.peripheral_irq_enables =
                  keep_defined(i_wdata, `DCC_IEN_MASK);
            end
            `DCC_OFS_PORT_DATA: s_nxt.port_latch = i_wdata;
            default: ;
         endcase
      end

      if (cfg_access) begin
         s_nxt.last_read = cur;
      end

      // set wins, no change is lost
      if (mismatch) begin
         s_nxt.peripheral_irq_flags[`DCC_BIT_CHANGE] = 1'b1;
      end

      // register reads, data one cycle later
      s_nxt.rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            `DCC_OFS_GIC: begin
               s_nxt.rdata = s_r.global_interrupt_control;
            end
            `DCC_OFS_FLAGS: begin
               s_nxt.rdata = s_r.peripheral_irq_flags;
            end
            `DCC_OFS_CFG: begin
               s_nxt.rdata = cfg_readback(cur, s_r.comparator_config);
            end
            `DCC_OFS_DIR: begin
               s_nxt.rdata = s_r.port_pin_direction;
            end
            `DCC_OFS_IEN: begin
               s_nxt.rdata = s_r.peripheral_irq_enables;
            end
            `DCC_OFS_PORT_DATA: begin
               s_nxt.rdata = port_read(s_r.pin_s2, mode);
            end
            default: s_nxt.rdata = 8'h00;
         endcase
      end

      s_nxt.irq =
         change_armed(s_r.peripheral_irq_flags,
                      s_r.peripheral_irq_enables,
                      s_r.global_interrupt_control) &
         s_r.global_interrupt_control[`DCC_BIT_GLOBAL_EN];
      s_nxt.wake = i_sleep &
         change_armed(s_r.peripheral_irq_flags,
                      s_r.peripheral_irq_enables,
                      s_r.global_interrupt_control);

      s_nxt.pins.oe = ~s_r.port_pin_direction;
      s_nxt.pins.out = pin_drive(s_r.port_latch, raw_inv, route_pins);

      s_nxt.analog.vref_to_positive = mode_uses_vref(mode);
      s_nxt.analog.alt_negative =
         s_r.comparator_config.input_switch_select &&
         mode_uses_switch(mode);
      s_nxt.analog.power_en = mode_powered(mode);
   end

   // nothing here reacts to sleep or wake
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r.global_interrupt_control <= `DCC_RST_GIC;
         s_r.peripheral_irq_flags <= `DCC_RST_FLAGS;
         s_r.comparator_config <= `DCC_RST_CFG;
         s_r.port_pin_direction <= `DCC_RST_DIR;
         s_r.peripheral_irq_enables <= `DCC_RST_IEN;
         s_r.port_latch <= `DCC_RST_LATCH;
         s_r.pin_s1 <= 8'h00;
         s_r.pin_s2 <= 8'h00;
         s_r.cmp_s1 <= 2'h0;
         s_r.cmp_s2 <= 2'h0;
         s_r.last_read <= 2'h0;
         s_r.rdata <= 8'h00;
         s_r.irq <= 1'b0;
         s_r.wake <= 1'b0;
         s_r.pins.out <= 8'h00;
         s_r.pins.oe <= 8'h00;
         s_r.analog.vref_to_positive <= 1'b0;
         s_r.analog.alt_negative <= 1'b0;
         s_r.analog.power_en <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rdata = s_r.rdata;
   assign o_vref_to_positive = s_r.analog.vref_to_positive;
   assign o_alt_negative = s_r.analog.alt_negative;
   assign o_cmp_power_en = s_r.analog.power_en;
   assign o_pin_out = s_r.pins.out;
   assign o_pin_oe = s_r.pins.oe;
   assign o_irq = s_r.irq;
   assign o_wake = s_r.wake;

endmodule : dcc_top

// *** tb/dcc_analog.sv ***
// behavioural comparator cores facing the control block
`timescale 1ns/1ps
module dcc_analog (
   // commanded analog levels
   input wire logic [1:0] i_above,
   input wire logic i_vref_above,
   // control from the block
   input wire logic i_vref_to_positive,
   input wire logic i_power_en,
   // raw results
   output logic [1:0] o_cmp_raw
);
   // compare, reference on positives, off when unpowered
   always_comb begin
      if (!i_power_en) o_cmp_raw = 2'b00;
      else if (i_vref_to_positive) o_cmp_raw = {2{i_vref_above}};
      else o_cmp_raw = i_above;
   end
endmodule : dcc_analog

// *** tb/dcc_top_assertions.sv ***
// port checks of the comparator control
`timescale 1ns/1ps
module dcc_chk (
   // clock, reset, register port
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // analog, pins, system
   input wire logic o_vref_to_positive,
   input wire logic o_alt_negative,
   input wire logic o_cmp_power_en,
   input wire logic [7:0] o_pin_oe,
   input wire logic i_sleep,
   input wire logic o_irq,
   input wire logic o_wake
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   wire cfg_wr = i_wr && i_addr == 8'h1f;
   AST_VREF: assert property (cfg_wr |-> ##2
      o_vref_to_positive == ($past(i_wdata[2:0], 2) == 3'h2))
      else $error("reference routing wrong");
   AST_PWR: assert property (cfg_wr |-> ##2 o_cmp_power_en ==
      !($past(i_wdata[2:0], 2) inside {3'h0, 3'h7}))
      else $error("power enable wrong");
   AST_ALT: assert property (cfg_wr |-> ##2 o_alt_negative ==
      ($past(i_wdata[3], 2) && $past(i_wdata[2:0], 2) inside {3'h1, 3'h2}))
      else $error("negative input select wrong");
   AST_OE: assert property (i_wr && i_addr == 8'h85 |-> ##2
      o_pin_oe == ~$past(i_wdata, 2)) else $error("pin enable wrong");
   AST_IRQ: assert property (i_wr && i_addr == 8'h0b && !i_wdata[7]
      |-> ##2 !o_irq) else $error("request without global enable");
   AST_WAKE: assert property (!i_sleep [*3] |-> !o_wake)
      else $error("wake while awake");
   AST_RST: assert property ($fell(i_rst) |->
      !o_cmp_power_en && o_pin_oe == 8'h00) else $error("reset state wrong");
   AST_CFG: assert property (cfg_wr ##1 i_rd && i_addr == 8'h1f
      |=> o_rdata[5:0] == $past(i_wdata[5:0], 2))
      else $error("config readback wrong");
   cover property (o_irq);
   cover property (o_wake);
   cover property (o_vref_to_positive);
endmodule : dcc_chk
bind dcc_top dcc_chk u_dcc_chk (.*);

// *** tb/tb.sv ***
// register level test of the comparator control
`timescale 1ns/1ps
module tb;
   logic clk = 0, rst = 1, wr = 0, rd = 0, slp = 0, vab = 0;
   logic [7:0] a = 0, d = 0, pin = 0;
   logic [1:0] abv = 0, raw;
   wire [7:0] rdat, po, oe;
   wire vp, an, pw, irq, wk;
   int fails = 0, total_checks = 0, cyc = 0;
   dcc_top u_dcc_top (.i_core_clk(clk), .i_rst(rst), .i_addr(a),
      .i_wdata(d), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_cmp_raw(raw),
      .o_vref_to_positive(vp), .o_alt_negative(an), .o_cmp_power_en(pw),
      .i_pin_in(pin), .o_pin_out(po), .o_pin_oe(oe), .i_sleep(slp),
      .o_irq(irq), .o_wake(wk));
   dcc_analog u_dcc_analog (.i_above(abv), .i_vref_above(vab),
      .i_vref_to_positive(vp), .i_power_en(pw), .o_cmp_raw(raw));
   initial forever #10 clk = ~clk;
   task give_verdict;
      if (fails == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         give_verdict();
      end
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %0t %h %h", $time, g, e);
      end
   endtask : chk
   task w(input logic [7:0] ad, input logic [7:0] dt);
      a <= ad;
      d <= dt;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask : w
   task r(input logic [7:0] ad, input logic [7:0] e);
      a <= ad;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      @(negedge clk);
      chk(rdat, e);
      @(posedge clk);
   endtask : r
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      @(negedge clk);
      chk({5'h0, vp, an, pw}, 8'h00);
      chk(oe, 8'h00);
      @(posedge clk);
      r(8'h1f, 8'h00);
      r(8'h0c, 8'h00);
      r(8'h85, 8'hff);
      r(8'h8c, 8'h00);
      w(8'h1f, 8'hc0);
      r(8'h1f, 8'h00);
      w(8'h1f, 8'hff);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({5'h0, vp, an, pw}, 8'h00);
      @(posedge clk);
      r(8'h1f, 8'hff);
      w(8'h1f, 8'h02);
      vab <= 1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({5'h0, vp, an, pw}, 8'h05);
      @(posedge clk);
      r(8'h1f, 8'hc2);
      w(8'h1f, 8'h03);
      repeat (4) @(posedge clk);
      r(8'h1f, 8'h03);
      w(8'h0c, 8'h00);
      abv <= 2'b01;
      repeat (4) @(posedge clk);
      r(8'h0c, 8'h40);
      w(8'h0c, 8'h00);
      r(8'h0c, 8'h40);
      r(8'h1f, 8'h43);
      w(8'h0c, 8'h00);
      r(8'h0c, 8'h00);
      w(8'h8c, 8'h40);
      @(posedge clk);
      w(8'h0b, 8'hc0);
      @(posedge clk);
      w(8'h0c, 8'h40);
      repeat (3) @(negedge clk);
      chk({7'h0, irq}, 8'h01);
      @(posedge clk);
      w(8'h0b, 8'h40);
      repeat (3) @(negedge clk);
      chk({7'h0, irq}, 8'h00);
      @(posedge clk);
      slp <= 1;
      repeat (3) @(negedge clk);
      chk({7'h0, wk}, 8'h01);
      @(posedge clk);
      slp <= 0;
      r(8'h1f, 8'h43);
      w(8'h8c, 8'h00);
      @(posedge clk);
      w(8'h85, 8'he7);
      @(posedge clk);
      w(8'h1f, 8'h06);
      abv <= 2'b10;
      pin <= 8'hff;
      repeat (4) @(negedge clk);
      chk({6'h0, po[4:3]}, 8'h02);
      chk(oe, 8'h18);
      @(posedge clk);
      r(8'h05, 8'hf8);
      w(8'h1f, 8'h09);
      abv <= 2'b01;
      repeat (3) @(negedge clk);
      chk({5'h0, vp, an, pw}, 8'h03);
      chk({6'h0, po[4:3]}, 8'h01);
      give_verdict();
   end
endmodule : tb
